// >>> lsdc_line_if.sv
`timescale 1ns/1ps
`default_nettype none

interface lsdc_line_if #(
  parameter int IDX_W = 8,
  parameter int TAG_W = 22
);
  logic [IDX_W-1:0] index;
  logic             wrEn;
  logic             wrValid;
  logic [TAG_W-1:0] wrTag;
  logic [31:0]      wrData;
  logic             rdValid;
  logic [TAG_W-1:0] rdTag;
  logic [31:0]      rdData;

  modport owner (
    output index, wrEn, wrValid, wrTag, wrData,
    input  rdValid, rdTag, rdData
  );
  modport store (
    input  index, wrEn, wrValid, wrTag, wrData,
    output rdValid, rdTag, rdData
  );
endinterface

`default_nettype wire

// >>> lsdc_line_store.sv
`timescale 1ns/1ps
`default_nettype none

module lsdc_line_store #(
  parameter int LINES = 256,
  parameter int IDX_W = 8,
  parameter int TAG_W = 22
) (
  input wire logic    clk,
  input wire logic    rst,
  lsdc_line_if.store  line
);
  logic [LINES-1:0] validBits;
  logic [TAG_W-1:0] tagMem [LINES];
  logic [31:0]      dataMem [LINES];
  logic             rdValid_reg;
  logic [TAG_W-1:0] rdTag_reg;
  logic [31:0]      rdData_reg;

  if (LINES != (1 << IDX_W)) begin : g_bad_lines
    $error("lsdc_line_store: LINES must equal 2**IDX_W");
  end

  // Valid bits reset so a stale tag can never hit in simulation
  for (genvar g = 0; g < LINES; g++) begin : g_valid
    always_ff @(posedge clk) begin
      if (rst) begin
        validBits[g] <= 1'b0;
      end else if (line.wrEn && (line.index == IDX_W'(g))) begin
        validBits[g] <= line.wrValid;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (line.wrEn) begin
      tagMem[line.index]  <= line.wrTag;
      dataMem[line.index] <= line.wrData;
    end
  end

  // Registered read: old contents on a same-cycle write
  always_ff @(posedge clk) begin
    if (rst) begin
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= validBits[line.index];
    end
    rdTag_reg  <= tagMem[line.index];
    rdData_reg <= dataMem[line.index];
  end

  assign line.rdValid = rdValid_reg;
  assign line.rdTag   = rdTag_reg;
  assign line.rdData  = rdData_reg;
endmodule

`default_nettype wire

// >>> lsdc_load_store.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Memory reads always fetch an aligned word; address bits 1..0 forced zero.
// - Byte extract picks byte by operand B bits 1..0, replaces operand A.
// - Halfword extract picks a halfword of operand A likewise.
// - Byte stores use fixed lanes: register byte n to address 4k+n.
// - Low halfword goes to 4k, high halfword to 4k+2.
// - Dynamic byte and halfword stores take data from register zero.
// - Replicate copies lowest byte or halfword to every lane of register zero.
// - Word store writes a whole word from any register in one bus write.
// - Cache is direct mapped, line chosen by low word-address bits.
// - Each line holds a word, tag and valid; lines are bytes over four.
// - Load hit on matching valid tag returns cached word, no memory read.
// - Word stores update the line and also write memory.
// - Word store writes tag and sets valid so later loads hit.
// - Load miss reads memory, returns the word and fills the line.
// - Invalidate register write clears the line's valid bit.
// - Enable is status bit 17; invalidate register is control register 7.
// - Prefixed general or pointer word loads bypass the cache.
// - Unprefixed general and pointer loads use the cache when enabled.
// - Invalidate register is write only; reads return zero.
// - Stack word loads always use the cache when enabled.
module lsdc_load_store
  import lsdc_pkg::*;
#(
  parameter int LSDC_BYTES = lsdc_pkg::DCACHE_BYTES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Pipeline request
  input  wire logic              reqValid,
  input  wire lsdc_pkg::lsdc_op_t reqOp,
  input  wire logic [31:0]       reqAddr,
  input  wire logic [31:0]       reqData,
  input  wire logic [31:0]       reqOperandB,
  input  wire logic [3:0]        reqCtlIndex,
  input  wire logic              ioBypassPrefix,
  output logic                   reqReady,
  // Pipeline answer
  output logic                   respValid,
  output logic [31:0]            respData,
  output logic [31:0]            generalRegisterZero,
  output logic                   dcacheEnableBit,
  // Data bus
  output logic                   memReq,
  output logic                   memWrite,
  output logic [31:0]            memAddr,
  output logic [31:0]            memWdata,
  output logic [3:0]             memByteEn,
  input  wire logic              memAck,
  input  wire logic [31:0]       memRdata
);
  // ****************************************************************
  // Geometry
  // ****************************************************************
  // One word per line
  localparam int LINES = LSDC_BYTES / WORD_BYTES;
  localparam int IDX_W = (LINES > 1) ? $clog2(LINES) : 1;
  localparam int TAG_W = ADDR_W - 2 - IDX_W;

  if ((LINES < 2) || (LINES != (1 << IDX_W)) || (TAG_W < 1)) begin : g_bad
    $error("lsdc_load_store: cache size must be a power of two >= 8");
  end

  lsdc_line_if #(.IDX_W(IDX_W), .TAG_W(TAG_W)) lineBus ();

  lsdc_line_store #(
    .LINES (LINES),
    .IDX_W (IDX_W),
    .TAG_W (TAG_W)
  ) u_lines (
    .clk  (clk),
    .rst  (rst),
    .line (lineBus.store)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  lsdc_state_t  state_reg, state_next;
  logic [31:0]  addr_reg;
  logic         fill_reg, fill_next;
  logic         ready_reg;
  logic         respValid_reg, respValid_next;
  logic [31:0]  respData_reg, respData_next;
  logic [31:0]  r0_reg, r0_next;
  logic         cacheEn_reg, cacheEn_next;
  logic         memReq_reg, memReq_next;
  logic         memWrite_reg, memWrite_next;
  logic [31:0]  memAddr_reg, memAddr_next;
  logic [31:0]  memWdata_reg, memWdata_next;
  logic [3:0]   memByteEn_reg, memByteEn_next;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  wire isIdle      = (state_reg == S_IDLE);
  wire acceptReq   = reqValid && isIdle;
  wire isStackLoad = (reqOp == OP_STACK_WORD_LOAD);
  wire isWordLoad  = (reqOp == OP_WORD_LOAD) ||
                     (reqOp == OP_POINTER_WORD_LOAD) || isStackLoad;
  wire isWordStore = (reqOp == OP_WORD_STORE);
  wire isByteStore = (reqOp == OP_BYTE_STORE_DYNAMIC);
  wire isHalfStore = (reqOp == OP_HALFWORD_STORE_DYNAMIC);
  wire isStore     = isWordStore || isByteStore || isHalfStore;
  wire isCtlWrite  = (reqOp == OP_CTL_WRITE);
  wire isCtlInv    = isCtlWrite && (reqCtlIndex == CTL_DCACHE_INV);
  wire isCtlStatus = isCtlWrite && (reqCtlIndex == CTL_STATUS);
  wire [31:0] alignedAddr = {reqAddr[31:2], WORD_ALIGN};
  // Prefix bypass; stack loads ignore the prefix
  wire bypass   = ioBypassPrefix && !isStackLoad;
  wire useCache = cacheEn_reg && !bypass;

  // ****************************************************************
  // Store lanes and immediate results
  // ****************************************************************
  // Dynamic partial stores take register zero
  wire [31:0] storeData = isWordStore ? reqData : r0_reg;
  // Fixed byte lane from address bits
  wire [3:0]  byteLaneEn = BE_LANE0 << reqAddr[1:0];
  // Halfword lane from address bit 1
  wire [3:0]  halfLaneEn = reqAddr[1] ? BE_HALF_HIGH : BE_HALF_LOW;
  wire [3:0]  storeEn = isWordStore ? BE_WORD :
                        isByteStore ? byteLaneEn : halfLaneEn;
  wire [7:0]  extByte = reqData[{reqOperandB[1:0], 3'h0} +: 8];
  // Halfword chosen by operand B bit 1
  wire [15:0] extHalf = reqData[{reqOperandB[1], 4'h0} +: 16];
  wire [31:0] fillByte = {4{reqData[7:0]}};
  wire [31:0] fillHalf = {2{reqData[15:0]}};
  // Invalidate register reads back as zero
  wire [31:0] ctlRead = (reqCtlIndex == CTL_STATUS) ?
                        (cacheEn_reg ? DCACHE_EN_MASK : ZERO_WORD) :
                        ZERO_WORD;
  wire [31:0] instantResult =
      (reqOp == OP_BYTE_EXTRACT_DYNAMIC)     ? {24'h00_0000, extByte} :
      (reqOp == OP_HALFWORD_EXTRACT_DYNAMIC) ? {16'h0000, extHalf} :
      (reqOp == OP_BYTE_REPLICATE)           ? fillByte :
      (reqOp == OP_HALFWORD_REPLICATE)       ? fillHalf :
      (reqOp == OP_CTL_READ)                 ? ctlRead : ZERO_WORD;

  // ****************************************************************
  // Line access
  // ****************************************************************
  // Line index from low word-address bits
  wire [IDX_W-1:0] reqIndex = isCtlInv ? reqData[2 +: IDX_W]
                                       : reqAddr[2 +: IDX_W];
  wire [IDX_W-1:0] heldIndex = addr_reg[2 +: IDX_W];
  wire [TAG_W-1:0] heldTag   = addr_reg[31 -: TAG_W];
  wire lineHit = lineBus.rdValid && (lineBus.rdTag == heldTag);
  wire fillNow = (state_reg == S_MEMREAD) && memAck && fill_reg;
  // Word store writes tag and sets valid
  wire storeLine = acceptReq && cacheEn_reg && isWordStore;
  // Partial stores drop the line: cheaper than a read-modify of it
  wire dropLine  = acceptReq && cacheEn_reg && (isByteStore || isHalfStore);
  wire invLine   = acceptReq && isCtlInv;

  assign lineBus.index   = isIdle ? reqIndex : heldIndex;
  // Bypass loads never write the store; stores ignore the prefix
  assign lineBus.wrEn    = storeLine || dropLine || invLine || fillNow;
  assign lineBus.wrValid = storeLine || fillNow;
  assign lineBus.wrTag   = fillNow ? heldTag : reqAddr[31 -: TAG_W];
  // Miss fills the line with memory data
  assign lineBus.wrData  = fillNow ? memRdata : reqData;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_next     = state_reg;
    fill_next      = fill_reg;
    respValid_next = 1'b0;
    respData_next  = respData_reg;
    memReq_next    = memReq_reg;
    memWrite_next  = memWrite_reg;
    memAddr_next   = memAddr_reg;
    memWdata_next  = memWdata_reg;
    memByteEn_next = memByteEn_reg;
    case (state_reg)
      S_IDLE: begin
        if (acceptReq && isWordLoad && useCache) begin
          state_next = S_LOOKUP;
        end else if (acceptReq && isWordLoad) begin
          state_next     = S_MEMREAD;
          fill_next      = 1'b0;
          memReq_next    = 1'b1;
          memWrite_next  = 1'b0;
          memAddr_next   = alignedAddr;
          memByteEn_next = BE_WORD;
        end else if (acceptReq && isStore) begin
          state_next     = S_MEMWRITE;
          memReq_next    = 1'b1;
          memWrite_next  = 1'b1;
          memAddr_next   = alignedAddr;
          memWdata_next  = storeData;
          memByteEn_next = storeEn;
        end else if (acceptReq) begin
          respValid_next = 1'b1;
          respData_next  = instantResult;
        end
      end
      S_LOOKUP: begin
        if (lineHit) begin
          state_next     = S_IDLE;
          respValid_next = 1'b1;
          respData_next  = lineBus.rdData;
        end else begin
          state_next     = S_MEMREAD;
          fill_next      = 1'b1;
          memReq_next    = 1'b1;
          memWrite_next  = 1'b0;
          memAddr_next   = addr_reg;
          memByteEn_next = BE_WORD;
        end
      end
      S_MEMREAD: begin
        if (memAck) begin
          state_next     = S_IDLE;
          memReq_next    = 1'b0;
          respValid_next = 1'b1;
          respData_next  = memRdata;
        end
      end
      default: begin
        if (memAck) begin
          state_next     = S_IDLE;
          memReq_next    = 1'b0;
          memWrite_next  = 1'b0;
          respValid_next = 1'b1;
          respData_next  = ZERO_WORD;
        end
      end
    endcase
  end

  assign r0_next = !acceptReq ? r0_reg :
                   (reqOp == OP_BYTE_REPLICATE) ? fillByte :
                   (reqOp == OP_HALFWORD_REPLICATE) ? fillHalf : r0_reg;
  assign cacheEn_next = (acceptReq && isCtlStatus) ? reqData[EN_BIT]
                                                   : cacheEn_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      fill_reg  <= 1'b0;
      ready_reg <= 1'b1;
      addr_reg  <= ZERO_WORD;
    end else begin
      state_reg <= state_next;
      fill_reg  <= fill_next;
      ready_reg <= (state_next == S_IDLE);
      addr_reg  <= acceptReq ? alignedAddr : addr_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      respValid_reg <= 1'b0;
      respData_reg  <= ZERO_WORD;
      r0_reg        <= ZERO_WORD;
      cacheEn_reg   <= 1'b0;
    end else begin
      respValid_reg <= respValid_next;
      respData_reg  <= respData_next;
      r0_reg        <= r0_next;
      cacheEn_reg   <= cacheEn_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      memReq_reg    <= 1'b0;
      memWrite_reg  <= 1'b0;
      memAddr_reg   <= ZERO_WORD;
      memWdata_reg  <= ZERO_WORD;
      memByteEn_reg <= 4'h0;
    end else begin
      memReq_reg    <= memReq_next;
      memWrite_reg  <= memWrite_next;
      memAddr_reg   <= memAddr_next;
      memWdata_reg  <= memWdata_next;
      memByteEn_reg <= memByteEn_next;
    end
  end

  assign reqReady            = ready_reg;
  assign respValid           = respValid_reg;
  assign respData            = respData_reg;
  assign generalRegisterZero = r0_reg;
  assign dcacheEnableBit     = cacheEn_reg;
  assign memReq              = memReq_reg;
  assign memWrite            = memWrite_reg;
  assign memAddr             = memAddr_reg;
  assign memWdata            = memWdata_reg;
  assign memByteEn           = memByteEn_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_read_aligned: assert property (
    @(posedge clk) disable iff (rst)
    (memReq && !memWrite) |-> (memAddr[1:0] == WORD_ALIGN))
    else $error("memory read not word aligned");

  chk_byte_extract: assert property (
    @(posedge clk) disable iff (rst)
    (acceptReq && reqOp == OP_BYTE_EXTRACT_DYNAMIC) |=>
      respValid && (respData ==
        (($past(reqData) >> (8 * $past(reqOperandB[1:0]))) & 32'h0000_00FF)))
    else $error("byte extract result wrong");

  chk_byte_lane: assert property (
    @(posedge clk) disable iff (rst)
    (acceptReq && isByteStore) |=>
      memReq && memWrite && (memWdata == r0_reg) &&
      (memByteEn == (4'h1 << $past(reqAddr[1:0]))))
    else $error("byte store lane wrong");

  chk_fill_r0: assert property (
    @(posedge clk) disable iff (rst)
    (acceptReq && reqOp == OP_HALFWORD_REPLICATE) |=>
      (generalRegisterZero[31:16] == $past(reqData[15:0])) &&
      (generalRegisterZero[15:0] == $past(reqData[15:0])))
    else $error("halfword replicate wrong");

  chk_hit_no_read: assert property (
    @(posedge clk) disable iff (rst)
    (state_reg == S_LOOKUP && lineHit) |=>
      respValid && !memReq ##1 !memReq)
    else $error("cache hit touched memory");

  chk_store_through: assert property (
    @(posedge clk) disable iff (rst)
    (acceptReq && isWordStore) |=>
      memReq && memWrite && (memByteEn == BE_WORD) &&
      (memWdata == $past(reqData)))
    else $error("word store not written through");

  chk_miss_fill: assert property (
    @(posedge clk) disable iff (rst)
    (state_reg == S_LOOKUP && !lineHit) |=>
      (memReq && !memWrite) ##[0:1000] (memAck && lineBus.wrEn &&
      lineBus.wrValid))
    else $error("miss did not read and fill");

  chk_bypass_load: assert property (
    @(posedge clk) disable iff (rst)
    (acceptReq && isWordLoad && bypass) |=>
      memReq && !memWrite && !fill_reg)
    else $error("prefixed load used cache");

  chk_enable_bit: assert property (
    @(posedge clk) disable iff (rst)
    (acceptReq && isCtlStatus) |=> (dcacheEnableBit == $past(reqData[17])))
    else $error("enable bit not taken from bit 17");

  chk_hold_request: assert property (
    @(posedge clk) disable iff (rst)
    (memReq && !memAck) |=> memReq && $stable(memAddr) && $stable(memWrite))
    else $error("bus request dropped before ack");
endmodule

`default_nettype wire

// >>> lsdc_load_store_tb.sv
`timescale 1ns/1ps
`default_nettype none

module lsdc_load_store_tb;
  import lsdc_pkg::*;
  // Eight lines, so 0x08 and 0x28 share a line
  localparam int CB = 32;
  logic        clk, rst, reqValid, ioBypassPrefix, reqReady, respValid;
  logic        dcacheEnableBit, memReq, memWrite, memAck;
  lsdc_op_t    reqOp;
  logic [31:0] reqAddr, reqData, reqOperandB, respData, generalRegisterZero;
  logic [31:0] memAddr, memWdata, memRdata, lastAddr, lastWdata, rdata;
  logic [3:0]  reqCtlIndex, memByteEn, ackDelay, lastBe;
  logic [15:0] rdCount, wrCount, rdBase;
  int          failCount, checksDone;

  lsdc_load_store #(.LSDC_BYTES(CB)) u_lsdc_load_store (.clk, .rst,
    .reqValid, .reqOp, .reqAddr, .reqData, .reqOperandB, .reqCtlIndex,
    .ioBypassPrefix, .reqReady, .respValid, .respData, .generalRegisterZero,
    .dcacheEnableBit, .memReq, .memWrite, .memAddr, .memWdata, .memByteEn,
    .memAck, .memRdata);
  lsdc_mem_model u_lsdc_mem_model (.clk, .rst, .memReq, .memWrite, .memAddr,
    .memWdata, .memByteEn, .memAck, .memRdata, .ackDelay, .rdCount,
    .wrCount, .lastAddr, .lastBe, .lastWdata);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic req(input lsdc_op_t op, input logic [31:0] a, d, b,
                     input logic [3:0] ix, input logic pfx);
    int n;
    n = 0;
    reqOp = op;
    reqAddr = a;
    reqData = d;
    reqOperandB = b;
    reqCtlIndex = ix;
    ioBypassPrefix = pfx;
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    while (respValid !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("answer", 32'h1, {31'h0, respValid});
    rdata = respData;
    @(posedge clk);
    #1;
  endtask

  task automatic loadWord(input lsdc_op_t op, input logic [31:0] a,
                          input logic pfx);
    req(op, a, 32'h0, 32'h0, 4'h0, pfx);
  endtask

  task automatic ctl(input logic [3:0] ix, input logic [31:0] v);
    req(OP_CTL_WRITE, 32'h0, v, 32'h0, ix, 1'b0);
  endtask

  task automatic reads(input logic [15:0] n);
    check("memory reads", {16'h0, rdBase + n}, {16'h0, rdCount});
  endtask

  task automatic tExtract;
    logic [31:0] a;
    a = 32'h4433_2211;
    for (int i = 0; i < 4; i++) begin
      req(OP_BYTE_EXTRACT_DYNAMIC, 32'h0, a, 32'hFFFF_FFF0 | 32'(i), 4'h0, 1'b0);
      check("byte extract", {24'h0, a[8*i+:8]}, rdata);
    end
    for (int h = 0; h < 2; h++) begin
      req(OP_HALFWORD_EXTRACT_DYNAMIC, 32'h0, a, 32'(h*2), 4'h0, 1'b0);
      check("half extract", {16'h0, a[16*h+:16]}, rdata);
    end
    $display("extract test done");
  endtask

  task automatic tPartial;
    logic [15:0] hv;
    ackDelay = 4'h0;
    for (int i = 0; i < 4; i++) begin
      req(OP_BYTE_REPLICATE, 32'h0, 32'h0A00 + 32'(16 + i), 32'h0, 4'h0, 1'b0);
      check("r0 fill", {4{8'(16 + i)}}, generalRegisterZero);
      req(OP_BYTE_STORE_DYNAMIC, 32'h40 + 32'(i), 32'hFFFF_FFFF, 32'h0, 4'h0,
          1'b0);
      check("lane enable", {28'h0, 4'h1 << i}, {28'h0, lastBe});
      check("lane addr", 32'h40, lastAddr);
      check("lane data", {4{8'(16 + i)}}, lastWdata);
    end
    for (int h = 0; h < 2; h++) begin
      hv = (h == 1) ? 16'hBEEF : 16'hCAFE;
      req(OP_HALFWORD_REPLICATE, 32'h0, {16'h5678, hv}, 32'h0, 4'h0, 1'b0);
      check("half fill", {hv, hv}, rdata);
      req(OP_HALFWORD_STORE_DYNAMIC, 32'h44 + 32'(h*2), 32'h0, 32'h0, 4'h0,
          1'b0);
      check("half enable", h ? 32'hC : 32'h3, {28'h0, lastBe});
    end
    loadWord(OP_WORD_LOAD, 32'h46, 1'b0);
    check("merged half", 32'hBEEF_CAFE, rdata);
    loadWord(OP_WORD_LOAD, 32'h41, 1'b0);
    check("merged bytes", 32'h1312_1110, rdata);
    $display("partial store test done");
  endtask

  task automatic tCache;
    for (int i = 0; i < CB; i += 4) begin
      ctl(4'h7, 32'(i));
    end
    req(OP_WORD_STORE, 32'h28, 32'h600D_F00D, 32'h0, 4'h0, 1'b0);
    ctl(4'h0, DCACHE_EN_MASK);
    check("enable bit", 32'h1, {31'h0, dcacheEnableBit});
    req(OP_CTL_READ, 32'h0, 32'h0, 32'h0, 4'h0, 1'b0);
    check("status", DCACHE_EN_MASK, rdata & DCACHE_EN_MASK);
    ackDelay = 4'h3;
    req(OP_WORD_STORE, 32'h08, 32'hA5A5_5A5A, 32'h0, 4'h0, 1'b0);
    check("store data", 32'hA5A5_5A5A, lastWdata);
    check("store enable", 32'hF, {28'h0, lastBe});
    rdBase = rdCount;
    loadWord(OP_WORD_LOAD, 32'h0B, 1'b0);
    check("hit data", 32'hA5A5_5A5A, rdata);
    reads(16'h0);
    loadWord(OP_POINTER_WORD_LOAD, 32'h2A, 1'b0);
    check("miss data", 32'h600D_F00D, rdata);
    check("miss addr", 32'h28, lastAddr);
    reads(16'h1);
    loadWord(OP_WORD_LOAD, 32'h28, 1'b0);
    reads(16'h1);
    loadWord(OP_WORD_LOAD, 32'h28, 1'b1);
    reads(16'h2);
    loadWord(OP_WORD_LOAD, 32'h28, 1'b0);
    reads(16'h2);
    loadWord(OP_STACK_WORD_LOAD, 32'h28, 1'b1);
    check("stack data", 32'h600D_F00D, rdata);
    reads(16'h2);
    req(OP_CTL_READ, 32'h0, 32'h0, 32'h0, 4'h7, 1'b0);
    check("invalidate read", ZERO_WORD, rdata);
    ctl(4'h0, 32'h0);
    ctl(4'h7, 32'h28);
    ctl(4'h0, DCACHE_EN_MASK);
    loadWord(OP_WORD_LOAD, 32'h28, 1'b0);
    reads(16'h3);
    $display("cache test done");
  endtask

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failCount++;
    printVerdict;
  end

  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqOp = OP_WORD_LOAD;
    reqAddr = 32'h0;
    reqData = 32'h0;
    reqOperandB = 32'h0;
    reqCtlIndex = 4'h0;
    ioBypassPrefix = 1'b0;
    ackDelay = 4'h0;
    rdBase = 16'h0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    check("ready after reset", 32'h1, {31'h0, reqReady});
    check("enable after reset", 32'h0, {31'h0, dcacheEnableBit});
    tExtract;
    tPartial;
    tCache;
    printVerdict;
  end
endmodule

`default_nettype wire

// >>> lsdc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// Data bus memory with stretchable ack
// ****
module lsdc_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Data bus
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [3:0]  memByteEn,
  output logic             memAck,
  output logic [31:0]      memRdata,
  // Bench view
  input  wire logic [3:0]  ackDelay,
  output logic [15:0]      rdCount,
  output logic [15:0]      wrCount,
  output logic [31:0]      lastAddr,
  output logic [3:0]       lastBe,
  output logic [31:0]      lastWdata
);
  logic [31:0] mem [64];
  logic [3:0]  waitCnt;
  wire  [5:0]  idx = memAddr[7:2];

  // Read data toggles outside ack so stale data never looks valid
  always_ff @(posedge clk) begin
    if (rst) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= 32'h0;
      rdCount <= 16'h0;
      wrCount <= 16'h0;
      lastAddr <= 32'h0;
      lastBe <= 4'h0;
      lastWdata <= 32'h0;
      for (int i = 0; i < 64; i++) begin
        mem[i] <= 32'h0;
      end
    end else if (memAck || !memReq) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= ~memRdata;
    end else if (waitCnt != ackDelay) begin
      waitCnt <= waitCnt + 4'h1;
      memRdata <= ~memRdata;
    end else begin
      memAck <= 1'b1;
      lastAddr <= memAddr;
      lastBe <= memByteEn;
      lastWdata <= memWdata;
      if (memWrite) begin
        wrCount <= wrCount + 16'h1;
        memRdata <= ~memRdata;
        for (int b = 0; b < 4; b++) begin
          if (memByteEn[b]) begin
            mem[idx][8*b+:8] <= memWdata[8*b+:8];
          end
        end
      end else begin
        rdCount <= rdCount + 16'h1;
        memRdata <= mem[idx];
      end
    end
  end
endmodule

`default_nettype wire

// >>> lsdc_pkg.sv
`default_nettype none

package lsdc_pkg;

  // ****************************************************************
  // Widths and lanes
  // ****************************************************************
  localparam int          ADDR_W        = 32;
  localparam int          DATA_W        = 32;
  localparam int          WORD_BYTES    = 4;
  localparam int          DCACHE_BYTES  = 1024;
  localparam int          EN_BIT        = 17;
  localparam logic [31:0] DCACHE_EN_MASK = 32'h0002_0000;

  // ****************************************************************
  // Control register indices
  // ****************************************************************
  localparam logic [3:0]  CTL_STATUS    = 4'h0;
  localparam logic [3:0]  CTL_DCACHE_INV = 4'h7;

  // ****************************************************************
  // Byte enables and reset values
  // ****************************************************************
  localparam logic [3:0]  BE_WORD       = 4'hF;
  localparam logic [3:0]  BE_LANE0      = 4'h1;
  localparam logic [3:0]  BE_HALF_LOW   = 4'h3;
  localparam logic [3:0]  BE_HALF_HIGH  = 4'hC;
  localparam logic [1:0]  WORD_ALIGN    = 2'h0;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ****************************************************************
  // Operations and states
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_WORD_LOAD,
    OP_POINTER_WORD_LOAD,
    OP_STACK_WORD_LOAD,
    OP_WORD_STORE,
    OP_BYTE_EXTRACT_DYNAMIC,
    OP_HALFWORD_EXTRACT_DYNAMIC,
    OP_BYTE_STORE_DYNAMIC,
    OP_HALFWORD_STORE_DYNAMIC,
    OP_BYTE_REPLICATE,
    OP_HALFWORD_REPLICATE,
    OP_CTL_WRITE,
    OP_CTL_READ
  } lsdc_op_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_LOOKUP,
    S_MEMREAD,
    S_MEMWRITE
  } lsdc_state_t;

endpackage

`default_nettype wire
